// *** verification/akr_host_model.sv ***
// Host side model: plays the demodulator waveform and times data output edges
`timescale 1ns/1ps
module akr_host_model (
  input  wire logic        core_clk,
  input  wire logic        run,
  input  wire logic        idleLevel,
  input  wire logic [15:0] halfPer,
  input  wire logic [15:0] gridCyc,
  input  wire logic        clrStats,
  input  wire logic        dataOut,
  output logic             demodIn,
  output logic [15:0]      minGap,
  output logic [7:0]       edgeCnt,
  output logic [7:0]       offGrid
);
  logic [15:0] waveCnt  = 16'h0000;
  logic [15:0] gapCnt   = 16'h0000;
  logic        lastData = 1'b0;
  logic        seenEdge = 1'b0;

  // ----------------------------------------------------------------------
  // Waveform source
  // ----------------------------------------------------------------------
  initial demodIn = 1'b0;

  // Square wave with steady spacing, idle level while stopped
  always @(posedge core_clk) begin
    if (!run) begin
      waveCnt <= 16'h0000;
      demodIn <= idleLevel;
    end else if (waveCnt >= halfPer - 16'h0001) begin
      waveCnt <= 16'h0000;
      demodIn <= ~demodIn;
    end else begin
      waveCnt <= waveCnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Edge timing
  // ----------------------------------------------------------------------
  // First edge after a clear is counted and starts the gap timer, no gap checks
  always @(posedge core_clk) begin
    lastData <= dataOut;
    gapCnt   <= gapCnt + 16'h0001;
    if (clrStats) begin
      minGap   <= 16'hFFFF;
      edgeCnt  <= 8'h00;
      offGrid  <= 8'h00;
      seenEdge <= 1'b0;
    end else if (dataOut !== lastData) begin
      gapCnt   <= 16'h0001;
      seenEdge <= 1'b1;
      edgeCnt  <= edgeCnt + 8'h01;
      if (seenEdge && gapCnt < minGap) minGap <= gapCnt;
      if (seenEdge && (gapCnt % gridCyc) != 16'h0000) offGrid <= offGrid + 8'h01;
    end
  end
endmodule : akr_host_model

// *** verification/test_akr_data_sync.sv ***
// Self-checking bench for the ASK receiver data back end
`timescale 1ns/1ps
module test_akr_data_sync;
  import akr_pkg::*;

  logic         core_clk  = 1'b0;
  logic         reset     = 1'b1;
  akr_apb_req_t apbReq    = '0;
  akr_apb_rsp_t apbRsp;
  logic         demodIn;
  logic         dataOut;
  logic         run       = 1'b0;
  logic         idleLevel = 1'b0;
  logic         clrStats  = 1'b0;
  logic [15:0]  halfPer   = 16'h0010;
  logic [15:0]  gridCyc   = 16'h0014;
  logic [15:0]  minGap;
  logic [7:0]   edgeCnt;
  logic [7:0]   offGrid;
  logic [31:0]  rdData;
  logic         rdErr;
  int           badCount   = 0;
  int           checksDone = 0;
  int           cyc        = 0;

  // ----------------------------------------------------------------------
  // Clock, instances
  // ----------------------------------------------------------------------
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  akr_data_sync akr_data_sync_inst (
    .core_clk (core_clk), .reset (reset), .apbReq (apbReq),
    .apbRsp (apbRsp), .demodIn (demodIn), .dataOut (dataOut));

  akr_host_model akr_host_model_inst (
    .core_clk (core_clk), .run (run), .idleLevel (idleLevel), .halfPer (halfPer),
    .gridCyc (gridCyc), .clrStats (clrStats), .dataOut (dataOut), .demodIn (demodIn),
    .minGap (minGap), .edgeCnt (edgeCnt), .offGrid (offGrid));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic completeRun();
    $display("Comparisons %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : completeRun

  task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : checkWord

  task automatic checkSpan(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checksDone++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      badCount++;
      $display("MISMATCH at %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : checkSpan

  // One APB transfer, held until pready is seen at a rising edge
  task automatic apbXfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge core_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (apbRsp.pready === 1'b1) break;
    end
    if (n == 20) begin
      badCount++;
      completeRun();
    end else begin
      rdData = apbRsp.prdata;
      rdErr  = apbRsp.pslverr;
      apbReq.psel    <= 1'b0;
      apbReq.penable <= 1'b0;
    end
  endtask : apbXfer

  task automatic clearStats();
    clrStats <= 1'b1;
    @(posedge core_clk);
    clrStats <= 1'b0;
    @(posedge core_clk);
  endtask : clearStats

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic testRegs();
    apbXfer(1'b0, CTRL_ADDR, 32'h0);
    checkWord(rdData, 32'h0000_0020);
    apbXfer(1'b0, STAT_ADDR, 32'h0);
    checkWord(rdData & 32'h0000_001F, 32'h0);
    apbXfer(1'b1, CTRL_ADDR, 32'hFFFF_FFF0);
    apbXfer(1'b0, CTRL_ADDR, 32'h0);
    checkWord(rdData, 32'h0000_00F0);
    apbXfer(1'b1, STAT_ADDR, 32'h0000_00FF);
    checkWord({31'h0, rdErr}, 32'h0);
    apbXfer(1'b0, STAT_ADDR, 32'h0);
    checkWord(rdData & 32'h0000_001F, 32'h0);
    apbXfer(1'b0, 12'h008, 32'h0);
    checkWord({31'h0, rdErr}, 32'h1);
    checkWord(rdData, 32'h0);
    apbXfer(1'b1, CTRL_ADDR, 32'h0000_0020);
    $display("registers test done");
  endtask : testRegs

  task automatic testAsleep();
    clearStats();
    halfPer <= 16'h001E;
    run     <= 1'b1;
    repeat (400) @(posedge core_clk);
    run <= 1'b0;
    checkWord({24'h0, edgeCnt}, 32'h0);
    apbXfer(1'b0, STAT_ADDR, 32'h0);
    checkWord({30'h0, rdData[1:0]}, 32'h0);
    $display("sleep test done");
  endtask : testAsleep

  task automatic testWake();
    int start;
    int n;
    clearStats();
    apbXfer(1'b1, CTRL_ADDR, 32'h0000_001D);
    start = cyc;
    apbXfer(1'b0, STAT_ADDR, 32'h0);
    checkWord({30'h0, rdData[1:0]}, 32'h1);
    checkWord({30'h0, rdData[4:3]}, 32'h2);
    for (n = 0; n < 3000 && rdData[1:0] !== 2'h2; n++) apbXfer(1'b0, STAT_ADDR, 32'h0);
    if (rdData[1:0] !== 2'h2) begin
      badCount++;
      completeRun();
    end
    checkSpan(cyc - start, 5120, 5150);
    repeat (200) @(posedge core_clk);
    apbXfer(1'b0, STAT_ADDR, 32'h0);
    checkWord({30'h0, rdData[1:0]}, 32'h2);
    idleLevel <= 1'b1;
    repeat (100) @(posedge core_clk);
    apbXfer(1'b0, STAT_ADDR, 32'h0);
    checkWord({30'h0, rdData[1:0]}, 32'h2);
    checkWord({24'h0, edgeCnt}, 32'h0);
    idleLevel <= 1'b0;
    repeat (100) @(posedge core_clk);
    apbXfer(1'b0, STAT_ADDR, 32'h0);
    checkWord({30'h0, rdData[1:0]}, 32'h3);
    $display("wake test done");
  endtask : testWake

  // Each rate range and both regions, edges on the scaled tick grid
  task automatic testRates();
    logic [31:0] ctrlTab[4] = '{32'h11, 32'h15, 32'h19, 32'h1B};
    logic [15:0] gridTab[4] = '{16'd80, 16'd40, 16'd20, 16'd28};
    logic [31:0] rngTab[4]  = '{32'h0, 32'h1, 32'h2, 32'h2};
    for (int i = 0; i < 4; i++) begin
      apbXfer(1'b1, CTRL_ADDR, ctrlTab[i]);
      apbXfer(1'b0, STAT_ADDR, 32'h0);
      checkWord({30'h0, rdData[4:3]}, rngTab[i]);
      checkWord({30'h0, rdData[1:0]}, 32'h3);
      repeat (100) @(posedge core_clk);
      gridCyc <= gridTab[i];
      halfPer <= gridTab[i] * 16'd2 + 16'd7;
      clearStats();
      run <= 1'b1;
      repeat (14 * (gridTab[i] * 2 + 7)) @(posedge core_clk);
      run <= 1'b0;
      checkSpan({24'h0, edgeCnt}, 10, 15);
      checkWord({24'h0, offGrid}, 32'h0);
      checkSpan({16'h0, minGap}, gridTab[i], 32'hFFFF);
    end
    $display("rate test done");
  endtask : testRates

  task automatic testSpikes();
    apbXfer(1'b1, CTRL_ADDR, 32'h0000_0049);
    gridCyc <= 16'd20;
    halfPer <= 16'd25;
    repeat (100) @(posedge core_clk);
    clearStats();
    run <= 1'b1;
    repeat (1000) @(posedge core_clk);
    run <= 1'b0;
    checkSpan({24'h0, edgeCnt}, 4, 15);
    checkSpan({16'h0, minGap}, 80, 32'hFFFF);
    checkWord({24'h0, offGrid}, 32'h0);
    // Idle input must bring the output back to its idle level
    repeat (200) @(posedge core_clk);
    checkWord({31'h0, dataOut}, 32'h0);
    $display("spike test done");
  endtask : testSpikes

  task automatic testDisable();
    apbXfer(1'b1, CTRL_ADDR, 32'h0000_0048);
    apbXfer(1'b0, STAT_ADDR, 32'h0);
    checkWord({29'h0, rdData[2:0]}, 32'h0);
    checkWord({31'h0, dataOut}, 32'h0);
    clearStats();
    run <= 1'b1;
    repeat (300) @(posedge core_clk);
    run <= 1'b0;
    checkWord({24'h0, edgeCnt}, 32'h0);
    $display("disable test done");
  endtask : testDisable

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    testRegs();
    testAsleep();
    testWake();
    testRates();
    testSpikes();
    testDisable();
    completeRun();
  end
endmodule : test_akr_data_sync

// *** verilog/akr_data_sync.sv ***
// ASK receiver data back end: tick generation, wake sequence, data resampling
//
// Operation
// - One base tick derived by crystal divider
// - Region low gives 2.0383 us base tick
// - Region high gives 2.0697 us base tick
// - Rate pins decode to range, 11 ambiguous
// - Scaled tick is 8, 4, 2, 1 base; 1 never used, rate pins 11 give 2
// - Enable low: sleep, processing off, input ignored
// - Enable high starts range-dependent settle period
// - After settling, demodulated data reaches output
// - Receive starts at a falling input edge
// - Receive holds until enable goes low
// - Data resampled on scaled tick only
// - Output edge spacing is whole scaled ticks
// - Minimum output edge spacing suppresses spikes
`timescale 1ns/1ps
module akr_data_sync (
  input  wire logic           core_clk,
  input  wire logic           reset,
  input  wire akr_pkg::akr_apb_req_t apbReq,
  output akr_pkg::akr_apb_rsp_t      apbRsp,
  input  wire logic           demodIn,
  output logic                dataOut
);
  import akr_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  akr_ctrl_t  ctrlQ;
  akr_stat_t  statNow;
  akr_state_t stateQ;
  akr_state_t stateD;
  logic [1:0] rangeNow;
  logic [3:0] factorNow;
  logic [7:0] baseDiv;
  logic       baseTick;
  logic       xTick;
  logic       asleep;
  logic [9:0] settleCntQ;
  logic       settleDone;
  logic       sampQ;
  logic [3:0] holdQ;
  logic       edgeOk;
  logic       fallSeen;
  logic       setupPh;
  logic       accessPh;
  logic       addrHit;
  logic [31:0] readMux;

  // ----------------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------------
  // Range and factors from the control register
  assign rangeNow  = rateRange(ctrlQ.rateSel);
  assign factorNow = xFactor(rangeNow);
  assign baseDiv   = ctrlQ.region ? DIV_HIGH : DIV_LOW;
  assign asleep    = (stateQ == ST_SLEEP);

  // ----------------------------------------------------------------------
  // Tick generation
  // ----------------------------------------------------------------------
  // Base tick from the crystal; stopped while asleep
  akr_tick_div u_base_div (
    .core_clk (core_clk),
    .reset    (reset),
    .clear    (asleep),
    .advance  (1'b1),
    .period   (baseDiv),
    .tick     (baseTick)
  );

  // Scaled tick counts base ticks
  akr_tick_div u_scaled_div (
    .core_clk (core_clk),
    .reset    (reset),
    .clear    (asleep),
    .advance  (baseTick),
    .period   ({4'h0, factorNow}),
    .tick     (xTick)
  );

  // ----------------------------------------------------------------------
  // Wake sequencer
  // ----------------------------------------------------------------------
  assign settleDone = baseTick && (settleCntQ >= settleTicks(rangeNow) - 10'h001);
  assign fallSeen   = xTick && sampQ && !demodIn;

  // Next state
  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      ST_SLEEP: begin
        if (ctrlQ.enable) begin
          stateD = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (!ctrlQ.enable) begin
          stateD = ST_SLEEP;
        end else if (settleDone) begin
          stateD = ST_ARM;
        end
      end
      ST_ARM: begin
        if (!ctrlQ.enable) begin
          stateD = ST_SLEEP;
        end else if (fallSeen) begin
          stateD = ST_RECV;
        end
      end
      ST_RECV: begin
        if (!ctrlQ.enable) begin
          stateD = ST_SLEEP;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stateQ <= ST_SLEEP;
    end else begin
      stateQ <= stateD;
    end
  end

  // Settle counter in base ticks
  always_ff @(posedge core_clk) begin
    if (reset || stateQ != ST_SETTLE) begin
      settleCntQ <= 10'h000;
    end else if (baseTick) begin
      settleCntQ <= settleCntQ + 10'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Data resampling and debounce
  // ----------------------------------------------------------------------
  assign edgeOk = (sampQ != dataOut) && (holdQ >= ctrlQ.minEdge);

  // Resample the demodulator on the scaled tick
  always_ff @(posedge core_clk) begin
    if (reset || asleep) begin
      sampQ <= DATA_IDLE;
    end else if (xTick) begin
      sampQ <= demodIn;
    end
  end

  // Scaled ticks since the last output edge, saturating
  always_ff @(posedge core_clk) begin
    if (reset || stateQ != ST_RECV) begin
      holdQ <= 4'h1;
    end else if (xTick) begin
      if (edgeOk) begin
        holdQ <= 4'h1;
      end else if (holdQ != 4'hF) begin
        holdQ <= holdQ + 4'h1;
      end
    end
  end

  // Data output, idle outside receive
  always_ff @(posedge core_clk) begin
    if (reset || stateQ != ST_RECV) begin
      dataOut <= DATA_IDLE;
    end else if (xTick && edgeOk) begin
      dataOut <= sampQ;
    end
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  assign setupPh  = apbReq.psel && !apbReq.penable;
  assign accessPh = apbReq.psel && apbReq.penable && apbRsp.pready;
  assign addrHit  = (apbReq.paddr == CTRL_ADDR) || (apbReq.paddr == STAT_ADDR);

  // Status view
  always_comb begin
    statNow.sample  = sampQ;
    statNow.range   = rangeNow;
    statNow.dataOut = dataOut;
    statNow.state   = stateQ;
  end

  // Read mux, unused bits zero
  always_comb begin
    readMux = 32'h0000_0000;
    if (apbReq.paddr == CTRL_ADDR) begin
      readMux = {24'h00_0000, ctrlQ};
    end else if (apbReq.paddr == STAT_ADDR) begin
      readMux = {26'h00_0000, statNow};
    end
  end

  // Control register write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrlQ <= akr_ctrl_t'(CTRL_RST);
    end else if (accessPh && apbReq.pwrite && apbReq.paddr == CTRL_ADDR) begin
      ctrlQ <= akr_ctrl_t'(apbReq.pwdata[7:0]);
    end
  end

  // Answer one cycle after setup, zero wait states
  always_ff @(posedge core_clk) begin
    if (reset) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready  <= setupPh;
      apbRsp.pslverr <= setupPh && !addrHit;
      apbRsp.prdata  <= (setupPh && !apbReq.pwrite) ? readMux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [4:0] cycSinceBaseQ;
  logic       seenBaseQ;
  logic [3:0] baseSinceXQ;
  logic       seenXQ;

  // Cycles between base ticks; region change restarts
  always_ff @(posedge core_clk) begin
    if (reset || asleep || $changed(ctrlQ.region)) begin
      cycSinceBaseQ <= 5'h00;
      seenBaseQ     <= 1'b0;
    end else if (baseTick) begin
      cycSinceBaseQ <= 5'h01;
      seenBaseQ     <= 1'b1;
    end else if (cycSinceBaseQ != 5'h1F) begin
      cycSinceBaseQ <= cycSinceBaseQ + 5'h01;
    end
  end

  // Base ticks between scaled ticks; range change restarts
  always_ff @(posedge core_clk) begin
    if (reset || asleep || $changed(rangeNow) || $changed(ctrlQ.region)) begin
      baseSinceXQ <= 4'h0;
      seenXQ      <= 1'b0;
    end else if (xTick) begin
      baseSinceXQ <= 4'h0;
      seenXQ      <= 1'b1;
    end else if (baseTick) begin
      baseSinceXQ <= baseSinceXQ + 4'h1;
    end
  end

  sequence s_fall;
    xTick && sampQ && !demodIn;
  endsequence

  sequence s_armed;
    stateQ == ST_ARM && ctrlQ.enable;
  endsequence

  property p_baseGap;
    @(posedge core_clk) disable iff (reset)
      baseTick |=> !baseTick [*8];
  endproperty
  a_baseGap: assert property (p_baseGap) else $error("base ticks too close");

  property p_basePeriod;
    @(posedge core_clk) disable iff (reset)
      baseTick && seenBaseQ && !$changed(ctrlQ.region)
        |-> {3'h0, cycSinceBaseQ} == baseDiv;
  endproperty
  a_basePeriod: assert property (p_basePeriod) else $error("base period wrong");

  property p_scaledPeriod;
    @(posedge core_clk) disable iff (reset)
      xTick && seenXQ && !$changed(rangeNow) |-> baseSinceXQ == factorNow;
  endproperty
  a_scaledPeriod: assert property (p_scaledPeriod) else $error("scaled period wrong");

  property p_range11;
    @(posedge core_clk) disable iff (reset)
      ctrlQ.rateSel == 2'h3 |-> statNow.range == 2'h2;
  endproperty
  a_range11: assert property (p_range11) else $error("range decode wrong");

  property p_sleep;
    @(posedge core_clk) disable iff (reset)
      !ctrlQ.enable |=> stateQ == ST_SLEEP ##1 dataOut == DATA_IDLE;
  endproperty
  a_sleep: assert property (p_sleep) else $error("not asleep");

  property p_wake;
    @(posedge core_clk) disable iff (reset)
      stateQ == ST_SLEEP && ctrlQ.enable |=> stateQ == ST_SETTLE;
  endproperty
  a_wake: assert property (p_wake) else $error("no settle on wake");

  property p_settleLen;
    @(posedge core_clk) disable iff (reset)
      $rose(stateQ == ST_ARM)
        |-> $past(settleCntQ) == settleTicks(rangeNow) - 10'h001 && $past(baseTick);
  endproperty
  a_settleLen: assert property (p_settleLen) else $error("settle length wrong");

  property p_idleBeforeRecv;
    @(posedge core_clk) disable iff (reset)
      stateQ != ST_RECV |=> dataOut == DATA_IDLE;
  endproperty
  a_idleBeforeRecv: assert property (p_idleBeforeRecv) else $error("data active early");

  property p_startOnFall;
    @(posedge core_clk) disable iff (reset)
      s_armed ##0 s_fall |=> stateQ == ST_RECV;
  endproperty
  a_startOnFall: assert property (p_startOnFall) else $error("missed falling start");

  property p_recvOnlyFall;
    @(posedge core_clk) disable iff (reset)
      $rose(stateQ == ST_RECV) |-> $past(xTick) && $past(sampQ) && !$past(demodIn);
  endproperty
  a_recvOnlyFall: assert property (p_recvOnlyFall) else $error("start not on fall");

  property p_recvHold;
    @(posedge core_clk) disable iff (reset)
      stateQ == ST_RECV && ctrlQ.enable |=> stateQ == ST_RECV;
  endproperty
  a_recvHold: assert property (p_recvHold) else $error("left receive");

  property p_edgeOnTick;
    @(posedge core_clk) disable iff (reset)
      $changed(dataOut) && $past(stateQ) == ST_RECV && stateQ == ST_RECV
        |-> $past(xTick);
  endproperty
  a_edgeOnTick: assert property (p_edgeOnTick) else $error("edge off tick");

  property p_minSpacing;
    @(posedge core_clk) disable iff (reset)
      $changed(dataOut) && $past(stateQ) == ST_RECV
        |-> $past(holdQ) >= $past(ctrlQ.minEdge);
  endproperty
  a_minSpacing: assert property (p_minSpacing) else $error("edges too close");

  property p_edgeFollowsSample;
    @(posedge core_clk) disable iff (reset)
      $changed(dataOut) && $past(stateQ) == ST_RECV |-> dataOut == $past(sampQ);
  endproperty
  a_edgeFollowsSample: assert property (p_edgeFollowsSample) else $error("bad level");

  property p_apbAnswer;
    @(posedge core_clk) disable iff (reset)
      setupPh && !apbRsp.pready |=> apbRsp.pready ##1 !apbRsp.pready;
  endproperty
  a_apbAnswer: assert property (p_apbAnswer) else $error("apb answer timing");

endmodule : akr_data_sync

// *** verilog/akr_pkg.sv ***
// Shared constants, types and lookups for the ASK receiver data back end
package akr_pkg;

  // ----------------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------------
  localparam real CORE_CLK_MHZ      = 50.0;      // Core clock, stands in for the crystal
  localparam real XTAL_LOW_MHZ      = 4.90625;   // Crystal with region select low
  localparam real XTAL_HIGH_MHZ     = 6.76438;   // Crystal with region select high
  localparam real BASE_PER_LOW_US   = 2.0383;    // Base tick period, region low
  localparam real BASE_PER_HIGH_US  = 2.0697;    // Base tick period, region high
  // Crystal cycles per base tick, derived from the periods above
  localparam logic [7:0] DIV_LOW    = 8'($rtoi(BASE_PER_LOW_US * XTAL_LOW_MHZ + 0.5));
  localparam logic [7:0] DIV_HIGH   = 8'($rtoi(BASE_PER_HIGH_US * XTAL_HIGH_MHZ + 0.5));

  // Scaled tick factors per rate range
  localparam logic [3:0] XFAC_R0    = 4'h8;
  localparam logic [3:0] XFAC_R1    = 4'h4;
  localparam logic [3:0] XFAC_R2    = 4'h2;
  localparam logic [3:0] XFAC_R3    = 4'h1;

  // Wake settle time in base ticks (half ticks rounded up)
  localparam logic [9:0] SETTLE_R0  = 10'h381;   // 896.5
  localparam logic [9:0] SETTLE_R1  = 10'h201;   // 512.5
  localparam logic [9:0] SETTLE_R2  = 10'h201;   // 512.5
  localparam logic [9:0] SETTLE_R3  = 10'h141;   // 320.5

  localparam logic       DATA_IDLE  = 1'b0;      // Data output level outside receive

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STAT_ADDR = 12'h004;
  localparam logic [7:0]  CTRL_RST  = 8'h20;     // Minimum edge spacing 2, asleep

  typedef enum logic [1:0] {ST_SLEEP, ST_SETTLE, ST_ARM, ST_RECV} akr_state_t;

  typedef struct packed {
    logic [3:0] minEdge;     // Least scaled ticks between data edges
    logic [1:0] rateSel;     // {rate_sel_msb, rate_sel_lsb}
    logic       region;      // Region select
    logic       enable;      // Wake request
  } akr_ctrl_t;

  typedef struct packed {
    logic       sample;      // Last resampled demodulator level
    logic [1:0] range;       // Decoded rate range
    logic       dataOut;     // Data output level
    akr_state_t state;       // Sequencer state
  } akr_stat_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } akr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } akr_apb_rsp_t;

  // ----------------------------------------------------------------------
  // Lookups
  // ----------------------------------------------------------------------
  // Rate pins to range; 11 maps to range 2 as printed
  function automatic logic [1:0] rateRange(input logic [1:0] sel);
    rateRange = (sel == 2'h3) ? 2'h2 : sel;
  endfunction : rateRange

  function automatic logic [3:0] xFactor(input logic [1:0] rng);
    unique case (rng)
      2'h0: xFactor = XFAC_R0;
      2'h1: xFactor = XFAC_R1;
      2'h2: xFactor = XFAC_R2;
      2'h3: xFactor = XFAC_R3;
    endcase
  endfunction : xFactor

  function automatic logic [9:0] settleTicks(input logic [1:0] rng);
    unique case (rng)
      2'h0: settleTicks = SETTLE_R0;
      2'h1: settleTicks = SETTLE_R1;
      2'h2: settleTicks = SETTLE_R2;
      2'h3: settleTicks = SETTLE_R3;
    endcase
  endfunction : settleTicks

endpackage : akr_pkg

// *** verilog/akr_tick_div.sv ***
// Tick divider: one-cycle pulse after each period of advance strobes
`timescale 1ns/1ps
module akr_tick_div (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       clear,
  input  wire logic       advance,
  input  wire logic [7:0] period,
  output logic            tick
);
  import akr_pkg::*;

  logic [7:0] cntQ;

  // Count advance strobes, wrap at the period
  always_ff @(posedge core_clk) begin
    if (reset || clear) begin
      cntQ <= 8'h00;
    end else if (advance) begin
      cntQ <= (cntQ >= period - 8'h01) ? 8'h00 : cntQ + 8'h01;
    end
  end

  // Registered tick on the wrapping strobe
  always_ff @(posedge core_clk) begin
    if (reset || clear) begin
      tick <= 1'b0;
    end else begin
      tick <= advance && (cntQ >= period - 8'h01);
    end
  end

  property p_tickWrap;
    @(posedge core_clk) disable iff (reset)
      tick |-> $past(advance) && $past(cntQ) >= $past(period) - 8'h01;
  endproperty
  a_tickWrap: assert property (p_tickWrap) else $error("tick without wrap");

endmodule : akr_tick_div
